/* design/pgo_pixel_datapath.sv */
`timescale 1ns/1ps
module pgo_pixel_datapath #(
	parameter int SMP_LOG2 = 4,
	parameter int DCL_LOG2 = 3
)(
	// clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// axi4-lite write
	input  wire logic [7:0]             awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	// axi4-lite read
	input  wire logic [7:0]             araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	// pixel stream
	input  wire pgo_pkg::pgo_pix_in_t   pix_in,
	output pgo_pkg::pgo_pix_out_t       pix_out,
	// coarse offset to the converters
	output logic [3:0][7:0]             ana_offset
);
	localparam int AW = 12 + SMP_LOG2;
	localparam int RW = 12 + DCL_LOG2;

	typedef struct packed {
		logic        valid;
		logic        rs;
		logic        drow;
		logic        dcol;
		logic        odd;
		logic [1:0]  color;
		logic [11:0] data;
	} pgo_s1_t;

	typedef struct packed {
		logic awready, wready, bvalid, arready, rvalid, aw_have, w_have, mnl_d;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic [1:0]  bresp, rresp;
		logic [31:0] rdata;
		logic [15:0] ctrl;
		logic [3:0][6:0]  dgain;
		logic [3:0][7:0]  again, ofs, pend, ana_o;
		logic [3:0]       pend_v;
		logic [11:0] target, tp_g, tp_r, tp_b, tp_data, bar_w;
		logic [7:0]  win;
		logic [3:0][1:0]  step;
		logic [3:0][11:0] dofs, eo_auto;
		logic [3:0][12:0] eo_man, rofs;
		logic [11:0] hcnt, vnext, vcur, walk, vbc, hbc;
		logic        col_odd, hbo;
		logic [2:0]  vbi;
		logic [3:0][AW-1:0] acc_e, acc_o;
		logic [3:0][SMP_LOG2-1:0] nsmp;
		logic [3:0][RW-1:0] rsum;
		logic [3:0][DCL_LOG2:0] rcnt;
		pgo_s1_t     s1;
		pgo_pkg::pgo_pix_out_t pout;
	} pgo_state_t;

	pgo_state_t     st_r;
	pgo_state_t     st_nxt;
	logic [3:0][7:0] eff;

	// ****************************************
	// offsets in use, with channel locks
	// ****************************************
	assign eff[0] = st_r.ofs[0];
	assign eff[1] = st_r.ofs[1];
	assign eff[2] = (st_r.ctrl[pgo_pkg::CTRL_LOCKRB] && st_r.again[1] == st_r.again[2]) ? st_r.ofs[1]
		: st_r.ofs[2];
	assign eff[3] = (st_r.ctrl[pgo_pkg::CTRL_LOCKG] && st_r.again[0] == st_r.again[3]) ? st_r.ofs[0]
		: st_r.ofs[3];

	function automatic logic hit(input logic [7:0] a);
		hit = (a[1:0] == 2'b00) && (a <= pgo_pkg::OFS_STAT);
	endfunction

	function automatic logic [31:0] reg_image(input logic [7:0] a);
		reg_image = 32'h0000_0000;
		case (a[7:4])
			pgo_pkg::OFS_AOFS[7:4]: reg_image = {24'h000000, eff[a[3:2]]};
			pgo_pkg::OFS_DOFS[7:4]: reg_image = {20'h00000, st_r.dofs[a[3:2]]};
			pgo_pkg::OFS_EO[7:4]:   reg_image = {19'h00000, st_r.eo_man[a[3:2]]};
			default: begin
				case (a)
					pgo_pkg::OFS_CTRL:  reg_image = {16'h0000, st_r.ctrl};
					pgo_pkg::OFS_DGAIN: reg_image = {1'b0, st_r.dgain[3], 1'b0, st_r.dgain[2],
						1'b0, st_r.dgain[1], 1'b0, st_r.dgain[0]};
					pgo_pkg::OFS_AGAIN: reg_image = st_r.again;
					pgo_pkg::OFS_BLK:   reg_image = {st_r.step, st_r.win, 4'h0, st_r.target};
					pgo_pkg::OFS_TPGR:  reg_image = {4'h0, st_r.tp_r, 4'h0, st_r.tp_g};
					pgo_pkg::OFS_TPBD:  reg_image = {4'h0, st_r.tp_data, 4'h0, st_r.tp_b};
					pgo_pkg::OFS_BARW:  reg_image = {20'h00000, st_r.bar_w};
					pgo_pkg::OFS_STAT:  reg_image = {12'h000, st_r.pend_v, 4'h0, st_r.vcur};
					default:            reg_image = 32'h0000_0000;
				endcase
			end
		endcase
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic                  mnl, act, arow, odd;
		logic [31:0]           msk, wd;
		logic [11:0]           hc, vn, vc, wk, cv, tpv, hbc, vbc;
		logic                  hbo;
		logic [2:0]            vbi;
		pgo_pkg::pgo_tp_mode_t tpm;
		logic [1:0]            c;
		logic [AW:0]           se, so;
		logic [11:0]           avg;
		logic [8:0]            up, dn;
		logic signed [13:0]    diff;
		logic signed [22:0]    prod;
		logic signed [23:0]    sum;
		logic signed [12:0]    dsel;
		logic signed [11:0]    eo;
		mnl = st_r.ctrl[pgo_pkg::CTRL_MANUAL];
		act = pix_in.valid && !pix_in.dark_row && !pix_in.dark_col;
		arow = pix_in.valid && pix_in.row_start && !pix_in.dark_row;
		msk = {{8{st_r.wstrb[3]}}, {8{st_r.wstrb[2]}}, {8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};
		wd = (reg_image(st_r.awaddr) & ~msk) | (st_r.wdata & msk);
		tpm = pgo_pkg::pgo_tp_mode_t'(st_r.ctrl[pgo_pkg::CTRL_TPMODE +: 4]);
		c = st_r.s1.color;
		se = '0;
		so = '0;
		avg = 12'h000;
		up = 9'h000;
		dn = 9'h000;
		st_nxt = st_r;
		st_nxt.mnl_d = mnl;
		st_nxt.ana_o = eff;

		// axi4-lite slave, address and data in either order
		if (awvalid && st_r.awready) begin
			st_nxt.aw_have = 1'b1;
			st_nxt.awready = 1'b0;
			st_nxt.awaddr = awaddr;
		end
		if (wvalid && st_r.wready) begin
			st_nxt.w_have = 1'b1;
			st_nxt.wready = 1'b0;
			st_nxt.wdata = wdata;
			st_nxt.wstrb = wstrb;
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have = 1'b0;
			st_nxt.awready = 1'b1;
			st_nxt.wready = 1'b1;
		end
		if (arvalid && st_r.arready) begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = hit(araddr) ? reg_image(araddr) : 32'h0000_0000;
			st_nxt.rresp = hit(araddr) ? pgo_pkg::RESP_OKAY : pgo_pkg::RESP_SLVERR;
		end
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end

		// test pattern counters, values for the current pixel
		odd = pix_in.row_start ? 1'b0 : st_r.col_odd;
		hc = pix_in.row_start ? 12'h000 : st_r.hcnt;
		wk = pix_in.row_start ? pgo_pkg::WALK_SEED : st_r.walk;
		vn = pix_in.frame_start ? 12'h000 : st_r.vnext;
		vc = arow ? vn : st_r.vcur;
		hbc = st_r.hbc;
		hbo = st_r.hbo;
		if (arow) begin
			if (vn == 12'h000 || st_r.hbc + 12'h001 >= st_r.bar_w) begin
				hbc = 12'h000;
				hbo = (vn == 12'h000) ? 1'b0 : ~st_r.hbo;
			end else
				hbc = st_r.hbc + 12'h001;
		end
		vbc = st_r.vbc + 12'h001;
		vbi = st_r.vbi;
		if (hc == 12'h000) begin
			vbc = 12'h000;
			vbi = 3'h0;
		end else if (vbc >= st_r.bar_w) begin
			vbc = 12'h000;
			vbi = st_r.vbi + 3'h1;
		end
		case (pix_in.color)
			pgo_pkg::COL_RED:  cv = st_r.tp_r;
			pgo_pkg::COL_BLUE: cv = st_r.tp_b;
			default:           cv = st_r.tp_g;
		endcase
		case (tpm)
			pgo_pkg::TP_HGRAD:   tpv = hc;
			pgo_pkg::TP_VGRAD:   tpv = vc;
			pgo_pkg::TP_DGRAD:   tpv = hc + vc;
			pgo_pkg::TP_CLASSIC: tpv = odd ? ~st_r.tp_data : st_r.tp_data;
			pgo_pkg::TP_WALK:    tpv = wk;
			pgo_pkg::TP_HBARS:   tpv = hbo ? st_r.tp_b : st_r.tp_g;
			pgo_pkg::TP_VBARS:   tpv = vbi[0] ? st_r.tp_b : st_r.tp_g;
			pgo_pkg::TP_CBARS: begin
				case (pix_in.color)
					pgo_pkg::COL_RED:  tpv = vbi[1] ? 12'h000 : pgo_pkg::PIX_MAX;
					pgo_pkg::COL_BLUE: tpv = vbi[0] ? 12'h000 : pgo_pkg::PIX_MAX;
					default:           tpv = vbi[2] ? 12'h000 : pgo_pkg::PIX_MAX;
				endcase
			end
			default:             tpv = cv;
		endcase
		if (pix_in.valid) begin
			st_nxt.col_odd = ~odd;
			st_nxt.hcnt = act ? hc + 12'h001 : hc;
			st_nxt.walk = act ? {wk[10:0], wk[11]} : wk;
			st_nxt.vnext = arow ? vn + 12'h001 : vn;
			st_nxt.vcur = vc;
			st_nxt.hbc = hbc;
			st_nxt.hbo = hbo;
			if (act) begin
				st_nxt.vbc = vbc;
				st_nxt.vbi = vbi;
			end
		end

		// stage 1: pattern substitution at the head
		st_nxt.s1.valid = pix_in.valid;
		st_nxt.s1.rs = pix_in.row_start;
		st_nxt.s1.drow = pix_in.dark_row;
		st_nxt.s1.dcol = pix_in.dark_col;
		st_nxt.s1.odd = odd;
		st_nxt.s1.color = pix_in.color;
		st_nxt.s1.data = pix_in.data;
		if (st_r.ctrl[pgo_pkg::CTRL_TPEN])
			st_nxt.s1.data = (pix_in.dark_row || pix_in.dark_col) ? cv : tpv;

		// row offset from the previous row's dark columns
		if (st_r.s1.valid && st_r.s1.rs) begin
			for (int i = 0; i < 4; i++) begin
				if (st_r.rcnt[i][DCL_LOG2])
					st_nxt.rofs[i] = 13'($signed({1'b0, st_r.target})
						- $signed({1'b0, 12'(st_r.rsum[i] >> DCL_LOG2)}));
				st_nxt.rsum[i] = '0;
				st_nxt.rcnt[i] = '0;
			end
		end
		if (st_r.s1.valid && st_r.s1.dcol && !st_nxt.rcnt[c][DCL_LOG2]) begin
			st_nxt.rsum[c] = st_nxt.rsum[c] + RW'(st_r.s1.data);
			st_nxt.rcnt[c] = st_nxt.rcnt[c] + 1'b1;
		end

		// analog calibration: sample dark rows, then adjust; idle in manual mode
		if (!mnl && st_r.s1.valid && st_r.s1.drow && !st_r.s1.dcol) begin
			se = {1'b0, st_r.acc_e[c]} + (st_r.s1.odd ? '0 : (AW+1)'(st_r.s1.data));
			so = {1'b0, st_r.acc_o[c]} + (st_r.s1.odd ? (AW+1)'(st_r.s1.data) : '0);
			st_nxt.acc_e[c] = AW'(se);
			st_nxt.acc_o[c] = AW'(so);
			st_nxt.nsmp[c] = st_r.nsmp[c] + 1'b1;
			if (&st_r.nsmp[c]) begin
				avg = 12'((se + so) >> SMP_LOG2);
				up = {1'b0, st_r.ofs[c]} + {1'b0, 8'h01 << st_r.step[c]};
				dn = {1'b0, st_r.ofs[c]} - {1'b0, 8'h01 << st_r.step[c]};
				if ({1'b0, avg} > {1'b0, st_r.target} + {5'h00, st_r.win})
					st_nxt.ofs[c] = up[8] ? pgo_pkg::AOFS_MAX : up[7:0];
				else if ({1'b0, avg} + {5'h00, st_r.win} < {1'b0, st_r.target})
					st_nxt.ofs[c] = dn[8] ? pgo_pkg::AOFS_RST : dn[7:0];
				st_nxt.eo_auto[c] = 12'(($signed({1'b0, se}) - $signed({1'b0, so})) >>> (SMP_LOG2 - 1));
				st_nxt.acc_e[c] = '0;
				st_nxt.acc_o[c] = '0;
			end
		end

		// entering manual mode releases held offset writes
		if (mnl && !st_r.mnl_d) begin
			for (int i = 0; i < 4; i++) begin
				if (st_r.pend_v[i]) begin
					st_nxt.ofs[i] = st_r.pend[i];
					st_nxt.pend_v[i] = 1'b0;
				end
			end
		end

		// register write, once address and data are both held
		if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = hit(st_r.awaddr) ? pgo_pkg::RESP_OKAY : pgo_pkg::RESP_SLVERR;
			if (hit(st_r.awaddr)) begin
				case (st_r.awaddr[7:4])
					pgo_pkg::OFS_AOFS[7:4]: begin
						if (mnl) begin
							st_nxt.ofs[st_r.awaddr[3:2]] = wd[7:0];
							st_nxt.pend_v[st_r.awaddr[3:2]] = 1'b0;
						end else begin
							st_nxt.pend[st_r.awaddr[3:2]] = wd[7:0];
							st_nxt.pend_v[st_r.awaddr[3:2]] = 1'b1;
						end
					end
					pgo_pkg::OFS_DOFS[7:4]: st_nxt.dofs[st_r.awaddr[3:2]] = wd[11:0];
					pgo_pkg::OFS_EO[7:4]:   st_nxt.eo_man[st_r.awaddr[3:2]] = wd[12:0];
					default: begin
						case (st_r.awaddr)
							pgo_pkg::OFS_CTRL:  st_nxt.ctrl = wd[15:0];
							pgo_pkg::OFS_DGAIN: begin
								for (int i = 0; i < 4; i++)
									st_nxt.dgain[i] = wd[8*i +: 7];
							end
							pgo_pkg::OFS_AGAIN: st_nxt.again = wd;
							pgo_pkg::OFS_BLK: begin
								st_nxt.target = wd[11:0];
								st_nxt.win = wd[23:16];
								st_nxt.step = wd[31:24];
							end
							pgo_pkg::OFS_TPGR: begin
								st_nxt.tp_g = wd[11:0];
								st_nxt.tp_r = wd[27:16];
							end
							pgo_pkg::OFS_TPBD: begin
								st_nxt.tp_b = wd[11:0];
								st_nxt.tp_data = wd[27:16];
							end
							pgo_pkg::OFS_BARW:  st_nxt.bar_w = wd[11:0];
							default:            st_nxt.bar_w = st_r.bar_w;
						endcase
					end
				endcase
			end
		end

		// stage 2: gain about black, then offsets, last before output
		diff = $signed({2'b00, st_r.s1.data}) - $signed({2'b00, st_r.target});
		prod = diff * $signed({1'b0, pgo_pkg::GAIN_ONE + {1'b0, st_r.dgain[c]}});
		// next-state row offset, so the first pixel of a row already gets its own row's value
		dsel = st_r.ctrl[pgo_pkg::CTRL_ROWCAL] ? $signed(st_nxt.rofs[c]) : 13'($signed(st_r.dofs[c]));
		eo = st_r.eo_man[c][pgo_pkg::EO_OVR] ? $signed(st_r.eo_man[c][11:0]) : $signed(st_r.eo_auto[c]);
		sum = 24'(prod >>> pgo_pkg::GAIN_FRAC) + $signed({12'h000, st_r.target}) + 24'(dsel)
			+ (st_r.s1.odd ? 24'(eo) : 24'sh000000);
		st_nxt.pout.valid = st_r.s1.valid;
		st_nxt.pout.dark = st_r.s1.drow || st_r.s1.dcol;
		st_nxt.pout.color = pgo_pkg::pgo_color_t'(c);
		if (st_r.s1.dcol)
			st_nxt.pout.data = st_r.s1.data;
		else if (sum < 0)
			st_nxt.pout.data = 12'h000;
		else if (sum > $signed({12'h000, pgo_pkg::PIX_MAX}))
			st_nxt.pout.data = pgo_pkg::PIX_MAX;
		else
			st_nxt.pout.data = sum[11:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.arready <= 1'b1;
			st_r.ctrl <= pgo_pkg::CTRL_RST;
			st_r.again <= pgo_pkg::AGAIN_RST;
			st_r.target <= pgo_pkg::TARGET_RST;
			st_r.win <= pgo_pkg::WIN_RST;
			st_r.bar_w <= pgo_pkg::BARW_RST;
			st_r.walk <= pgo_pkg::WALK_SEED;
			st_r.mnl_d <= pgo_pkg::CTRL_RST[pgo_pkg::CTRL_MANUAL];
		end else
			st_r <= st_nxt;
	end

	assign awready = st_r.awready;
	assign wready = st_r.wready;
	assign bvalid = st_r.bvalid;
	assign bresp = st_r.bresp;
	assign arready = st_r.arready;
	assign rvalid = st_r.rvalid;
	assign rdata = st_r.rdata;
	assign rresp = st_r.rresp;
	assign pix_out = st_r.pout;
	assign ana_offset = st_r.ana_o;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	write_resp_a: assert property (st_r.aw_have && st_r.w_have && !st_r.bvalid |=> bvalid [*1] ##0 $past(st_r.aw_have))
		else $error("write response missing");
	manual_idle_a: assert property (st_r.ctrl[0] && st_r.mnl_d |=> $stable(st_r.acc_e) && $stable(st_r.nsmp))
		else $error("calibration ran in manual mode");
	green_lock_a: assert property (st_r.ctrl[2] && st_r.again[0] == st_r.again[3]
		|=> ana_offset[3] == $past(st_r.ofs[0]))
		else $error("green lock not applied");
	rb_lock_a: assert property (st_r.ctrl[3] && st_r.again[1] == st_r.again[2]
		|=> ana_offset[2] == $past(st_r.ofs[1]))
		else $error("red/blue lock not applied");
	held_write_a: assert property (st_r.aw_have && st_r.w_have && !st_r.bvalid && !st_r.ctrl[0]
		&& st_r.awaddr == 8'h10 && st_r.wstrb[0] |=> st_r.pend_v[0] && st_r.pend[0] == $past(st_r.wdata[7:0]))
		else $error("auto-mode write not held");
	walk_start_a: assert property (pix_in.valid && pix_in.row_start && !pix_in.dark_row && !pix_in.dark_col
		&& st_r.ctrl[4] && st_r.ctrl[11:8] == 4'h5 |=> st_r.s1.data == 12'h001 ##1 pix_out.valid)
		else $error("walking ones does not start at one");
	hgrad_a: assert property (pix_in.valid && !pix_in.row_start && !pix_in.dark_row && !pix_in.dark_col
		&& st_r.ctrl[4] && st_r.ctrl[11:8] == 4'h1 |=> st_r.s1.data == $past(st_r.hcnt))
		else $error("horizontal gradient wrong");
	read_ofs_a: assert property (arvalid && arready && araddr == 8'h14 |=> rvalid && rdata[7:0] == $past(eff[1]))
		else $error("offset read not the value in use");

endmodule // pgo_pixel_datapath

/* pkg/pgo_pkg.sv */
package pgo_pkg;

	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_DGAIN = 8'h04;
	localparam logic [7:0] OFS_AGAIN = 8'h08;
	localparam logic [7:0] OFS_BLK   = 8'h0C;
	localparam logic [7:0] OFS_AOFS  = 8'h10;
	localparam logic [7:0] OFS_DOFS  = 8'h20;
	localparam logic [7:0] OFS_EO    = 8'h30;
	localparam logic [7:0] OFS_TPGR  = 8'h40;
	localparam logic [7:0] OFS_TPBD  = 8'h44;
	localparam logic [7:0] OFS_BARW  = 8'h48;
	localparam logic [7:0] OFS_STAT  = 8'h4C;

	// ****************************************
	// control field positions
	// ****************************************
	localparam int CTRL_MANUAL = 0;
	localparam int CTRL_ROWCAL = 1;
	localparam int CTRL_LOCKG  = 2;
	localparam int CTRL_LOCKRB = 3;
	localparam int CTRL_TPEN   = 4;
	localparam int CTRL_TPMODE = 8;
	localparam int EO_OVR      = 12;

	// ****************************************
	// reset values and constants
	// ****************************************
	localparam logic [15:0] CTRL_RST   = 16'h0001;
	localparam logic [31:0] AGAIN_RST  = 32'h0808_0808;
	localparam logic [11:0] TARGET_RST = 12'h0A8;
	localparam logic [7:0]  WIN_RST    = 8'h04;
	localparam logic [11:0] BARW_RST   = 12'h010;
	localparam logic [7:0]  AOFS_RST   = 8'h00;
	localparam logic [7:0]  AOFS_MAX   = 8'hFF;
	localparam logic [11:0] WALK_SEED  = 12'h001;
	localparam logic [11:0] PIX_MAX    = 12'hFFF;
	localparam logic [7:0]  GAIN_ONE   = 8'h08;
	localparam int          GAIN_FRAC  = 3;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		COL_G1 = 2'b00, COL_RED = 2'b01, COL_BLUE = 2'b10, COL_G2 = 2'b11
	} pgo_color_t;

	typedef enum logic [3:0] {
		TP_FIELD = 4'h0, TP_HGRAD = 4'h1, TP_VGRAD = 4'h2, TP_DGRAD = 4'h3, TP_CLASSIC = 4'h4,
		TP_WALK = 4'h5, TP_HBARS = 4'h6, TP_VBARS = 4'h7, TP_CBARS = 4'h8
	} pgo_tp_mode_t;

	typedef struct packed {
		logic        valid;
		logic        frame_start;
		logic        row_start;
		logic        dark_row;
		logic        dark_col;
		pgo_color_t  color;
		logic [11:0] data;
	} pgo_pix_in_t;

	typedef struct packed {
		logic        valid;
		logic        dark;
		pgo_color_t  color;
		logic [11:0] data;
	} pgo_pix_out_t;

endpackage

/* tb/pgo_host_capture.sv */
`timescale 1ns/1ps
// ****************************************
// host side capturing the pixel words
// ****************************************
module pgo_host_capture (
	// clock
	input  wire logic                  aclk,
	// stream from the device
	input  wire pgo_pkg::pgo_pix_out_t pix_out,
	// last word and running count
	output logic [11:0]                cap_data,
	output logic [2:0]                 cap_tag,
	output int                         cap_count
);
	initial cap_count = 0;
	// no back-pressure: the host takes every word it is offered
	always @(posedge aclk) begin
		if (pix_out.valid === 1'b1) begin
			cap_data <= pix_out.data;
			cap_tag <= {pix_out.dark, pix_out.color};
			cap_count <= cap_count + 1;
		end
	end
endmodule // pgo_host_capture

/* tb/test_pixel_gain_offset_testpattern.sv */
`timescale 1ns/1ps
module test_pixel_gain_offset_testpattern;
	// ****************************************
	// signals
	// ****************************************
	logic                  aclk = 1'b0;
	logic                  aresetn = 1'b0;
	logic [7:0]            awaddr = 8'h00;
	logic                  awvalid = 1'b0;
	logic                  awready;
	logic [31:0]           wdata = 32'h0;
	logic [3:0]            wstrb = 4'hF;
	logic                  wvalid = 1'b0;
	logic                  wready;
	logic [1:0]            bresp;
	logic                  bvalid;
	logic                  bready = 1'b0;
	logic [7:0]            araddr = 8'h00;
	logic                  arvalid = 1'b0;
	logic                  arready;
	logic [31:0]           rdata;
	logic [1:0]            rresp;
	logic                  rvalid;
	logic                  rready = 1'b0;
	pgo_pkg::pgo_pix_in_t  pix_in = '0;
	pgo_pkg::pgo_pix_out_t pix_out;
	logic [3:0][7:0]       ana_offset;
	logic [11:0]           cap_data;
	logic [2:0]            cap_tag;
	int                    cap_count;
	int                    failures = 0;
	int                    samples_checked = 0;
	logic [11:0]           q0;
	logic [11:0]           fld [4] = '{12'h123, 12'h456, 12'h789, 12'h123};

	always #20 aclk = ~aclk;

	pgo_pixel_datapath DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pix_in(pix_in),
		.pix_out(pix_out), .ana_offset(ana_offset));
	pgo_host_capture host (.aclk(aclk), .pix_out(pix_out), .cap_data(cap_data), .cap_tag(cap_tag),
		.cap_count(cap_count));

	// ****************************************
	// report and compare
	// ****************************************
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_pix(input logic [11:0] e, input logic [11:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED pixel expected %h seen %h", e, g);
		end
	endtask
	task automatic give_up(input string nm);
		failures++;
		$display("CHECK FAILED %s expected answer seen timeout", nm);
		final_report();
	endtask

	// ****************************************
	// bus and stream drivers
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = pgo_pkg::RESP_OKAY);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (n > 40) give_up("write");
		end while (bvalid !== 1'b1);
		chk_reg("bresp", {30'h0, er}, {30'h0, bresp});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = pgo_pkg::RESP_OKAY);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
			if (n > 40) give_up("read");
		end while (rvalid !== 1'b1);
		chk_reg("rdata", e, rdata);
		chk_reg("rresp", {30'h0, er}, {30'h0, rresp});
	endtask
	// f holds frame start, row start, dark column
	task automatic px(input logic [1:0] c, input logic [2:0] f, input logic [11:0] d, output logic [11:0] o);
		int n;
		int c0;
		n = 0;
		c0 = cap_count;
		pix_in <= {1'b1, f[2], f[1], 1'b0, f[0], c, d};
		@(posedge aclk);
		pix_in.valid <= 1'b0;
		while (cap_count == c0) begin
			@(posedge aclk);
			n++;
			if (n > 10) give_up("pixel");
		end
		o = cap_data;
	endtask
	task automatic pxc(input logic [1:0] c, input logic [2:0] f, input logic [11:0] d, input logic [11:0] e);
		logic [11:0] o;
		px(c, f, d, o);
		chk_pix(e, o);
	endtask
	task automatic tp(input logic [3:0] m);
		// manual bit kept set: calibration stays off while a pattern runs
		wr(pgo_pkg::OFS_CTRL, 32'h11 | (32'(m) << pgo_pkg::CTRL_TPMODE));
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(pgo_pkg::OFS_CTRL, 32'h1);
		rdc(pgo_pkg::OFS_AGAIN, 32'h0808_0808);
		rdc(8'h84, 32'h0, pgo_pkg::RESP_SLVERR);
		wr(8'h50, 32'h1, pgo_pkg::RESP_SLVERR);
		// gain code 8 doubles the swing around the target
		wr(pgo_pkg::OFS_DGAIN, 32'h8);
		pxc(0, 3'b010, 12'h300, 12'h558);
		pxc(0, 3'b011, 12'h300, 12'h300);
		wr(pgo_pkg::OFS_DOFS, 32'hFF0);
		pxc(0, 3'b010, 12'h300, 12'h548);
		wr(pgo_pkg::OFS_DOFS, 32'h7FF);
		pxc(0, 3'b010, 12'hFFF, 12'hFFF);
		wr(pgo_pkg::OFS_DGAIN, 32'h0);
		wr(pgo_pkg::OFS_DOFS, 32'h800);
		pxc(0, 3'b010, 12'h100, 12'h000);
		wr(pgo_pkg::OFS_DOFS, 32'h0);
		wr(pgo_pkg::OFS_EO, 32'h1000);
		wr(pgo_pkg::OFS_TPGR, 32'h0456_0123);
		wr(pgo_pkg::OFS_TPBD, 32'h05A5_0789);
		wr(pgo_pkg::OFS_BARW, 32'h2);
		tp(pgo_pkg::TP_FIELD);
		for (int c = 0; c < 4; c++) begin
			pxc(2'(c), 3'b010, 12'h000, fld[c]);
		end
		tp(pgo_pkg::TP_CLASSIC);
		pxc(0, 3'b010, 12'h000, 12'h5A5);
		pxc(0, 3'b000, 12'h000, 12'hA5A);
		pxc(1, 3'b011, 12'h000, 12'h456);
		tp(pgo_pkg::TP_WALK);
		pxc(0, 3'b010, 12'h000, 12'h001);
		pxc(0, 3'b000, 12'h000, 12'h002);
		pxc(0, 3'b000, 12'h000, 12'h004);
		tp(pgo_pkg::TP_HGRAD);
		px(0, 3'b010, 12'h000, q0);
		pxc(0, 3'b000, 12'h000, q0 + 12'h001);
		tp(pgo_pkg::TP_VGRAD);
		px(0, 3'b110, 12'h000, q0);
		pxc(0, 3'b010, 12'h000, q0 + 12'h001);
		tp(pgo_pkg::TP_DGRAD);
		px(0, 3'b110, 12'h000, q0);
		pxc(0, 3'b000, 12'h000, q0 + 12'h001);
		tp(pgo_pkg::TP_VBARS);
		for (int i = 0; i < 4; i++) begin
			pxc(0, (i == 0) ? 3'b010 : 3'b000, 12'h000, (i < 2) ? 12'h123 : 12'h789);
		end
		tp(pgo_pkg::TP_HBARS);
		pxc(0, 3'b110, 12'h000, 12'h123);
		pxc(0, 3'b010, 12'h000, 12'h123);
		pxc(0, 3'b010, 12'h000, 12'h789);
		tp(pgo_pkg::TP_CBARS);
		pxc(2, 3'b011, 12'h000, 12'h789);
		chk_reg("pix_tag", 32'h6, {29'h0, cap_tag});
		pxc(2, 3'b010, 12'h000, 12'hFFF);
		chk_reg("pix_tag", 32'h2, {29'h0, cap_tag});
		// row offset: target minus the average of the previous row's eight dark columns
		wr(pgo_pkg::OFS_CTRL, 32'h3);
		for (int i = 0; i < 8; i++) begin
			pxc(0, (i == 0) ? 3'b011 : 3'b001, 12'h0A0, 12'h0A0);
		end
		pxc(0, 3'b010, 12'h200, 12'h208);
		// coarse offsets: manual writes land at once, auto writes wait
		wr(pgo_pkg::OFS_CTRL, 32'h1);
		wr(pgo_pkg::OFS_AOFS, 32'h12);
		rdc(pgo_pkg::OFS_AOFS, 32'h12);
		chk_reg("ana_offset", 32'h12, {24'h0, ana_offset[0]});
		wr(pgo_pkg::OFS_CTRL, 32'h0);
		wr(pgo_pkg::OFS_AOFS, 32'h34);
		rdc(pgo_pkg::OFS_AOFS, 32'h12);
		chk_reg("ana_offset", 32'h12, {24'h0, ana_offset[0]});
		wr(pgo_pkg::OFS_CTRL, 32'h1);
		rdc(pgo_pkg::OFS_AOFS, 32'h34);
		wr(pgo_pkg::OFS_AOFS + 8'h0C, 32'h56);
		wr(pgo_pkg::OFS_CTRL, 32'h5);
		rdc(pgo_pkg::OFS_AOFS + 8'h0C, 32'h34);
		chk_reg("ana_offset", 32'h34, {24'h0, ana_offset[3]});
		wr(pgo_pkg::OFS_AOFS + 8'h04, 32'h21);
		wr(pgo_pkg::OFS_AOFS + 8'h08, 32'h43);
		wr(pgo_pkg::OFS_CTRL, 32'h9);
		rdc(pgo_pkg::OFS_AOFS + 8'h08, 32'h21);
		wr(pgo_pkg::OFS_AGAIN, 32'h0809_0808);
		rdc(pgo_pkg::OFS_AOFS + 8'h08, 32'h43);
		chk_reg("ana_offset", 32'h43, {24'h0, ana_offset[2]});
		final_report();
	end
endmodule // test_pixel_gain_offset_testpattern
